// ---- include/tmr8_params.svh ----
// constants for the 8-bit waveform timer: offsets, fields, resets, prescale taps
`ifndef TMR8_PARAMS_SVH
`define TMR8_PARAMS_SVH

// ==================================================================
// register offsets (plain port, 3-bit address)
`define TMR8_OFS_CTRL_A      3'h0
`define TMR8_OFS_COUNT      3'h1
`define TMR8_OFS_COMPARE    3'h2
`define TMR8_OFS_FLAGS      3'h3
`define TMR8_OFS_ENABLES    3'h4

// ==================================================================
// control register a field positions
`define TMR8_BIT_FORCE      7
`define TMR8_BIT_WGM_LOW    6
`define TMR8_BIT_COM_HI     5
`define TMR8_BIT_COM_LO     4
`define TMR8_BIT_WGM_HIGH   3
`define TMR8_BIT_CS_HI      2

// flag / enable bit positions
`define TMR8_BIT_OVF        0
`define TMR8_BIT_CMP        1

// ==================================================================
// reset values and counter extremes
`define TMR8_CTRL_RESET     8'h00
`define TMR8_BOTTOM         8'h00
`define TMR8_MAX            8'hFF

// prescaler tap masks (divide by 8, 32, 64, 128, 256, 1024)
`define TMR8_DIV8_MASK      10'h007
`define TMR8_DIV32_MASK     10'h01F
`define TMR8_DIV64_MASK     10'h03F
`define TMR8_DIV128_MASK    10'h07F
`define TMR8_DIV256_MASK    10'h0FF
`define TMR8_DIV1024_MASK   10'h3FF

`endif

// ---- include/tmr8_pkg.sv ----
// types shared by the 8-bit waveform timer
package tmr8_pkg;

  // ==================================================================
  // waveform modes, encoded as {high bit, low bit}
  typedef enum logic [1:0] {
    TMR8_WGM_NORMAL = 2'h0,
    TMR8_WGM_PHASE  = 2'h1,
    TMR8_WGM_CTC    = 2'h2,
    TMR8_WGM_FAST   = 2'h3
  } tmr8_wgm_type;

  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmr8_req_type;

  // decoded control register a
  typedef struct packed {
    tmr8_wgm_type wgm;
    logic [1:0]   com;
    logic [2:0]   cs;
  } tmr8_ctrl_type;

endpackage

// ---- verilog/tmr8_unit.sv ----
// 8-bit timer/counter with one compare channel and waveform generation
`timescale 1ns/1ps
`include "tmr8_params.svh"

// Summary of operation
// RULE1: fast pwm period is 256 ticks
// RULE2: prescaler offers 1,8,32,64,128,256,1024
// RULE3: fast pwm compare zero gives spike
// RULE4: fast pwm compare max holds level
// RULE5: fast pwm mode 1 toggles on match
// RULE6: mode 1 counts up then down
// RULE7: phase mode holds max one tick
// RULE8: phase: clear up-match, set down-match
// RULE9: phase com 2 normal, 3 inverted
// RULE10: phase mode overflow at bottom
// RULE11: phase pwm period is 510 ticks
// RULE12: phase extremes give constant output
// RULE13: at max output equals up-match result
// RULE14: missed up-match still changes at bottom
// RULE15: tick is a clock enable
// RULE16: force strobe forces match in non-pwm
// RULE17: forced match sets no flag, no clear
// RULE18: force strobe reads zero
// RULE19: software writes force zero in pwm
// RULE20: mode bits at 3 and 6
// RULE21: top and compare update per mode
// RULE22: overflow at max, bottom in phase
// RULE23: fast pwm wraps max to bottom
// RULE24: clock select picks stop or division
// RULE25: irq when flag and enable set
module tmr8_unit (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire tmr8_pkg::tmr8_req_type req_i,
  output logic [7:0]             rdata_o,
  output logic                   compare_output_pin_o,
  output logic                   compare_output_oe_o,
  output logic                   irq_o
);
  import tmr8_pkg::*;

  // ==================================================================
  // register state
  logic [7:0]    ctrl_q, ctrl_d;
  logic [7:0]    cnt_q, cnt_d;
  logic [7:0]    cmp_buf_q, cmp_buf_d;     // value software wrote
  logic [7:0]    cmp_q, cmp_d;             // value in use by the comparator
  logic [1:0]    flags_q, flags_d;
  logic [1:0]    ien_q, ien_d;
  logic          dir_down_q, dir_down_d;
  logic          level_q, level_d;
  logic          block_q, block_d;         // count write masks a match on the next tick only
  logic [9:0]    pre_q, pre_d;
  logic [7:0]    rdata_q, rdata_d;
  tmr8_ctrl_type ctl;
  logic          tick;
  logic          force_wr;
  logic          wr_ctrl, wr_cnt, wr_cmp, wr_flags, wr_ien;

  // field unpacking; mode bit positions are split
  assign ctl.wgm = tmr8_wgm_type'({ctrl_q[`TMR8_BIT_WGM_HIGH], ctrl_q[`TMR8_BIT_WGM_LOW]}); // [RULE20]
  assign ctl.com = ctrl_q[`TMR8_BIT_COM_HI:`TMR8_BIT_COM_LO];
  assign ctl.cs  = ctrl_q[`TMR8_BIT_CS_HI:0];

  // ==================================================================
  // address decode, used once per register
  function automatic logic hit(input tmr8_req_type r, input logic [2:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  assign wr_ctrl  = hit(req_i, `TMR8_OFS_CTRL_A);
  assign wr_cnt   = hit(req_i, `TMR8_OFS_COUNT);
  assign wr_cmp   = hit(req_i, `TMR8_OFS_COMPARE);
  assign wr_flags = hit(req_i, `TMR8_OFS_FLAGS);
  assign wr_ien   = hit(req_i, `TMR8_OFS_ENABLES);
  // strobe only acts in non-pwm modes; software keeps it zero otherwise
  assign force_wr = wr_ctrl && req_i.wdata[`TMR8_BIT_FORCE] &&
                    !req_i.wdata[`TMR8_BIT_WGM_LOW];            // [RULE16] [RULE19]

  // ==================================================================
  // prescaler: free-running, tick is a one-cycle enable
  always_comb begin
    pre_d = pre_q + 10'h001;
    case (ctl.cs)                                               // [RULE24] [RULE2]
      3'h0:    tick = 1'b0;
      3'h1:    tick = 1'b1;
      3'h2:    tick = (pre_q & `TMR8_DIV8_MASK) == `TMR8_DIV8_MASK;
      3'h3:    tick = (pre_q & `TMR8_DIV32_MASK) == `TMR8_DIV32_MASK;
      3'h4:    tick = (pre_q & `TMR8_DIV64_MASK) == `TMR8_DIV64_MASK;
      3'h5:    tick = (pre_q & `TMR8_DIV128_MASK) == `TMR8_DIV128_MASK;
      3'h6:    tick = (pre_q & `TMR8_DIV256_MASK) == `TMR8_DIV256_MASK;
      default: tick = (pre_q & `TMR8_DIV1024_MASK) == `TMR8_DIV1024_MASK;
    endcase
  end

  // ==================================================================
  // counter, compare, flags and waveform
  always_comb begin
    logic match;
    logic at_top;
    logic ovf_ev;
    logic cmp_ev;
    match      = 1'b0;
    at_top     = 1'b0;
    ovf_ev     = 1'b0;
    cmp_ev     = 1'b0;
    ctrl_d     = ctrl_q;
    cnt_d      = cnt_q;
    cmp_buf_d  = cmp_buf_q;
    cmp_d      = cmp_q;
    flags_d    = flags_q;
    ien_d      = ien_q;
    dir_down_d = dir_down_q;
    level_d    = level_q;
    block_d    = block_q;

    // counting, matches and flag events happen only on a tick; software writes act in any cycle
    if (tick) begin                                             // [RULE15]
      match   = (cnt_q == cmp_q) && !block_q;
      block_d = 1'b0;
      cmp_ev  = match;
      case (ctl.wgm)
        TMR8_WGM_NORMAL: begin
          cnt_d  = cnt_q + 8'h01;
          ovf_ev = (cnt_q == `TMR8_MAX);                        // [RULE22]
          if (match) begin
            level_d = (ctl.com == 2'h1) ? !level_q :
                      (ctl.com == 2'h2) ? 1'b0 :
                      (ctl.com == 2'h3) ? 1'b1 : level_q;
          end
        end
        TMR8_WGM_CTC: begin
          at_top = (cnt_q == cmp_q);                            // [RULE21]
          cnt_d  = at_top ? `TMR8_BOTTOM : cnt_q + 8'h01;
          ovf_ev = (cnt_q == `TMR8_MAX);                        // [RULE22]
          if (match) begin
            level_d = (ctl.com == 2'h1) ? !level_q :
                      (ctl.com == 2'h2) ? 1'b0 :
                      (ctl.com == 2'h3) ? 1'b1 : level_q;
          end
        end
        TMR8_WGM_FAST: begin
          // full 8-bit ramp, wraps after max
          at_top = (cnt_q == `TMR8_MAX);
          cnt_d  = cnt_q + 8'h01;                               // [RULE23] [RULE1]
          ovf_ev = at_top;                                      // [RULE22]
          if (ctl.com == 2'h1) begin
            if (match) level_d = !level_q;                      // [RULE5]
          end else if (ctl.com[1]) begin
            // match at max is ignored so the bottom level holds
            if (at_top) level_d = !ctl.com[0];                  // [RULE3]
            else if (match) level_d = ctl.com[0];               // [RULE4]
          end
          if (at_top) cmp_d = cmp_buf_q;                        // [RULE21]
        end
        default: begin
          // dual slope, one tick at max and at bottom each
          if (!dir_down_q) begin                                // [RULE6] [RULE11]
            cnt_d = cnt_q + 8'h01;
            if (cnt_q == `TMR8_MAX) begin
              cnt_d      = cnt_q - 8'h01;                       // [RULE7]
              dir_down_d = 1'b1;
              cmp_d      = cmp_buf_q;                           // [RULE21]
            end
          end else begin
            cnt_d = cnt_q - 8'h01;
            if (cnt_q == `TMR8_BOTTOM) begin
              cnt_d      = cnt_q + 8'h01;
              dir_down_d = 1'b0;
            end
          end
          ovf_ev = dir_down_q && (cnt_q == `TMR8_BOTTOM);       // [RULE10] [RULE22]
          if (ctl.com[1]) begin                                 // [RULE9]
            if (cnt_q == `TMR8_MAX) begin
              // level at max is the up-match result, for symmetry
              level_d = ctl.com[0] ^ (cmp_q == `TMR8_MAX);      // [RULE13] [RULE12]
            end else if (cnt_q == `TMR8_BOTTOM && dir_down_q) begin
              // start of up slope: level as if below the compare
              level_d = !ctl.com[0] ^ (cmp_q == `TMR8_BOTTOM);  // [RULE14] [RULE12]
            end else if (match) begin
              level_d = dir_down_q ? !ctl.com[0] : ctl.com[0];  // [RULE8]
            end
          end
        end
      endcase
    end

    // forced compare changes only the level; it acts with the mode written beside it
    if (force_wr) begin                                         // [RULE17]
      level_d = (req_i.wdata[`TMR8_BIT_COM_HI:`TMR8_BIT_COM_LO] == 2'h1) ? !level_q :
                (req_i.wdata[`TMR8_BIT_COM_HI:`TMR8_BIT_COM_LO] == 2'h2) ? 1'b0 :
                (req_i.wdata[`TMR8_BIT_COM_HI:`TMR8_BIT_COM_LO] == 2'h3) ? 1'b1 : level_q;
    end

    // software writes
    if (wr_ctrl) begin
      ctrl_d = req_i.wdata & 8'h7F;                             // [RULE18]
    end
    if (wr_cnt) begin
      cnt_d   = req_i.wdata;
      block_d = 1'b1;
    end
    if (wr_cmp) begin
      cmp_buf_d = req_i.wdata;
    end
    if (wr_ien) begin
      ien_d = req_i.wdata[1:0];
    end
    // immediate update modes follow the written value at once
    if (!ctl.wgm[0]) begin                                      // [RULE21]
      cmp_d = wr_cmp ? req_i.wdata : cmp_buf_q;
    end

    // flags clear by writing one; a same-cycle event wins
    if (wr_flags) begin
      flags_d = flags_q & ~req_i.wdata[1:0];
    end
    if (ovf_ev) flags_d[`TMR8_BIT_OVF] = 1'b1;
    if (cmp_ev) flags_d[`TMR8_BIT_CMP] = 1'b1;
  end

  // ==================================================================
  // read data, one cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (req_i.rd) begin
      if (req_i.addr == `TMR8_OFS_CTRL_A) begin
        rdata_d = ctrl_q;
      end else if (req_i.addr == `TMR8_OFS_COUNT) begin
        rdata_d = cnt_q;
      end else if (req_i.addr == `TMR8_OFS_COMPARE) begin
        rdata_d = cmp_buf_q;
      end else if (req_i.addr == `TMR8_OFS_FLAGS) begin
        rdata_d = {6'h00, flags_q};
      end else if (req_i.addr == `TMR8_OFS_ENABLES) begin
        rdata_d = {6'h00, ien_q};
      end
    end
  end

  // ==================================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_q     <= `TMR8_CTRL_RESET;
      cnt_q      <= `TMR8_BOTTOM;
      cmp_buf_q  <= 8'h00;
      cmp_q      <= 8'h00;
      flags_q    <= 2'h0;
      ien_q      <= 2'h0;
      dir_down_q <= 1'b0;
      level_q    <= 1'b0;
      block_q    <= 1'b0;
      pre_q      <= 10'h000;
      rdata_q    <= 8'h00;
    end else begin
      ctrl_q     <= ctrl_d;
      cnt_q      <= cnt_d;
      cmp_buf_q  <= cmp_buf_d;
      cmp_q      <= cmp_d;
      flags_q    <= flags_d;
      ien_q      <= ien_d;
      dir_down_q <= dir_down_d;
      level_q    <= level_d;
      block_q    <= block_d;
      pre_q      <= pre_d;
      rdata_q    <= rdata_d;
    end
  end

  // ==================================================================
  // outputs
  assign rdata_o              = rdata_q;
  assign compare_output_pin_o = level_q;
  assign compare_output_oe_o  = (ctl.com != 2'h0);
  assign irq_o                = |(flags_q & ien_q);             // [RULE25]

endmodule // tmr8_unit

// ---- sim/tmr8_chk.sv ----
// port checker for the 8-bit waveform timer
`timescale 1ns/1ps
module tmr8_chk (
  input wire logic                   clk_i,
  input wire logic                   rstn_i,
  input wire tmr8_pkg::tmr8_req_type req_i,
  input wire logic [7:0]             rdata_o,
  input wire logic                   compare_output_pin_o,
  input wire logic                   compare_output_oe_o,
  input wire logic                   irq_o
);
  import tmr8_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ==================================================================
  // register cycles
  sequence wr_s(a); req_i.wr && req_i.addr == a; endsequence
  sequence rd_s(a); req_i.rd && req_i.addr == a; endsequence
  // write, one idle cycle, read back the same place
  property back_p(a, m);
    wr_s(a) ##1 !req_i.wr ##1 rd_s(a) |=> (rdata_o & m) == ($past(req_i.wdata, 3) & m);
  endproperty
  // ==================================================================
  // assertions
  rst_quiet_a: assert property (disable iff (1'b0) !rstn_i |=> rdata_o == 8'h00 && !irq_o
    && !compare_output_oe_o && !compare_output_pin_o) else $error("outputs live in reset");
  idle_read_a: assert property (!$past(req_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  force_zero_a: assert property ($past(req_i.rd && req_i.addr == 3'h0) |-> !rdata_o[7])
    else $error("force strobe read as one");
  ctrl_back_a: assert property (back_p(3'h0, 8'h7F))
    else $error("control field readback wrong");
  en_back_a: assert property (back_p(3'h4, 8'h03))
    else $error("enable readback wrong");
  unmapped_zero_a: assert property ($past(req_i.rd) && $past(req_i.addr) > 3'h4 |->
    rdata_o == 8'h00) else $error("unmapped read not zero");
  oe_decode_a: assert property (wr_s(3'h0) |=>
    compare_output_oe_o == ($past(req_i.wdata[5:4]) != 2'h0)) else $error("enable decode");
  oe_steady_a: assert property ($changed(compare_output_oe_o) |->
    $past(req_i.wr && req_i.addr == 3'h0))
    else $error("pin enable moved without write");
  force_set_a: assert property (req_i.wr && req_i.addr == 3'h0 && req_i.wdata[7:3] == 5'h16
    |-> ##[1:2] compare_output_pin_o) else $error("forced set missing");
  force_clr_a: assert property (req_i.wr && req_i.addr == 3'h0 && req_i.wdata[7:3] == 5'h14
    |-> ##[1:2] !compare_output_pin_o) else $error("forced clear missing");
  irq_off_a: assert property (req_i.wr && req_i.addr == 3'h4 && req_i.wdata[1:0] == 2'h0
    |=> !irq_o)
    else $error("request with enables off");
endmodule // tmr8_chk

bind tmr8_unit tmr8_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i),
  .rdata_o(rdata_o), .compare_output_pin_o(compare_output_pin_o),
  .compare_output_oe_o(compare_output_oe_o), .irq_o(irq_o));

// ---- sim/tb_top.sv ----
// self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ps
module tb_top;
  import tmr8_pkg::*;
  logic         clk_i = 1'b0;
  logic         rstn_i = 1'b0;
  tmr8_req_type req_i = '0;
  logic [7:0]   rdata_o, d;
  logic         pin, oe, irq;
  int           fail_count = 0, total_checks = 0, seed = 3, p, hi, c, k;
  logic [7:0]   fv [4] = '{8'hB0, 8'hA0, 8'h90, 8'h90};
  logic         fe [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int           dv [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  // ==================================================================
  // clock and design
  always #2 clk_i = ~clk_i;
  tmr8_unit uut (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .rdata_o(rdata_o),
    .compare_output_pin_o(pin), .compare_output_oe_o(oe), .irq_o(irq));
  // ==================================================================
  // compare, report, bus cycles
  task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] v);
    @(posedge clk_i) req_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i) req_i <= '0;
  endtask
  // read into d, taken in the cycle after the strobe
  task automatic rd(logic [2:0] a);
    @(posedge clk_i) req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i) req_i <= '0;
    @(negedge clk_i) d = rdata_o;
  endtask
  task automatic rc(string n, logic [2:0] a, logic [7:0] e);
    rd(a);
    chk(n, {8'h00, d}, {8'h00, e});
  endtask
  // sync to a rising output edge, then time one period and its high part
  task automatic per;
    logic l;
    for (int j = 0; j < 2; j++) begin
      p = 0;
      hi = 0;
      do begin
        l = pin;
        @(negedge clk_i);
        p++;
        hi += (pin === 1'b1);
      end while (!(pin === 1'b1 && l === 1'b0) && p < 3000);
      if (p >= 3000) break;
    end
    if (p >= 3000) begin
      chk("pwm edge timeout", 16'h0, 16'h1);
      summarize();
    end
  endtask
  // ep of zero means the level must stay flat
  task automatic pw(logic [7:0] m, logic [7:0] v, int ep, int eh);
    wr(3'h2, v);
    wr(3'h0, m); // force bit kept zero in pwm modes
    repeat (600) @(negedge clk_i);
    if (ep == 0) begin
      hi = 0;
      repeat (600) @(negedge clk_i) hi += (pin === 1'b1);
    end else begin
      per();
      chk("period", p[15:0], ep[15:0]);
    end
    chk("high time", hi[15:0], eh[15:0]);
  endtask
  // ==================================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    rc("ctrl reset", 3'h0, 8'h00);
    chk("oe reset", {15'h0, oe}, 16'h0);
    wr(3'h4, 8'h03);
    rc("enables", 3'h4, 8'h03);
    rc("unmapped", 3'h5, 8'h00);
    wr(3'h0, 8'h30);
    for (k = 0; k < 4; k++) begin
      wr(3'h0, fv[k]);
      repeat (2) @(negedge clk_i);
      chk("forced level", {15'h0, pin}, {15'h0, fe[k]});
    end
    rc("ctrl after force", 3'h0, 8'h10);
    rc("flags after force", 3'h3, 8'h00);
    chk("irq after force", {15'h0, irq}, 16'h0);
    wr(3'h4, 8'h00);
    wr(3'h0, 8'h49);
    rc("mode fields", 3'h0, 8'h49);
    c = 1 + ($random(seed) & 32'h7F);
    pw(8'h69, c[7:0], 256, c + 1);
    pw(8'h69, 8'h00, 256, 1);
    pw(8'h59, 8'h00, 512, 256);
    pw(8'h69, 8'hFF, 0, 600);
    pw(8'h61, c[7:0], 510, 2 * c);
    pw(8'h71, c[7:0], 510, 510 - 2 * c);
    pw(8'h61, 8'h00, 0, 0);
    pw(8'h61, 8'hFF, 0, 600);
    pw(8'h71, 8'h00, 0, 600);
    wr(3'h0, 8'h00);
    wr(3'h3, 8'h03);
    wr(3'h4, 8'h01);
    wr(3'h0, 8'h01);
    k = 0;
    while (irq !== 1'b1 && k < 400) begin
      @(negedge clk_i);
      k++;
    end
    chk("overflow irq", {15'h0, irq}, 16'h1);
    if (k >= 400) summarize();
    wr(3'h4, 8'h00);
    @(negedge clk_i);
    chk("masked irq", {15'h0, irq}, 16'h0);
    for (k = 1; k < 8; k++) begin
      wr(3'h0, k[7:0]);
      wr(3'h1, 8'h00);
      repeat (dv[k] * 10) @(posedge clk_i);
      rd(3'h1);
      chk("prescaled count", {15'h0, d >= 8'd9 && d <= 8'd13}, 16'h1);
    end
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h05);
    repeat (50) @(posedge clk_i);
    rc("stopped count", 3'h1, 8'h05);
    summarize();
  end
endmodule // tb_top
